// ==== inc/tcc_pkg.sv ====
// register map, field positions, mode codes and state type of the capture/compare block
package tcc_pkg;
    localparam int unsigned ADDR_W      = 4;
    localparam int unsigned NCH         = 2;
    localparam int unsigned FILT_LEN    = 4;

    localparam logic [3:0]  ADDR_CTRL_A = 4'h0;
    localparam logic [3:0]  ADDR_CTRL_B = 4'h1;
    localparam logic [3:0]  ADDR_FLAGS  = 4'h2;
    localparam logic [3:0]  ADDR_IRQ_EN = 4'h3;
    localparam logic [3:0]  ADDR_CAP_LO = 4'h4;
    localparam logic [3:0]  ADDR_CAP_HI = 4'h5;
    localparam logic [3:0]  ADDR_CMPA_LO = 4'h6;
    localparam logic [3:0]  ADDR_CMPA_HI = 4'h7;
    localparam logic [3:0]  ADDR_CMPB_LO = 4'h8;
    localparam logic [3:0]  ADDR_CMPB_HI = 4'h9;

    // control a: mode in [3:0], output mode b in [5:4], output mode a in [7:6]
    localparam int unsigned CA_WGM_LSB  = 0;
    localparam int unsigned CA_COMB_LSB = 4;
    localparam int unsigned CA_COMA_LSB = 6;
    // control b
    localparam int unsigned CB_FORCE_A  = 0;
    localparam int unsigned CB_CMP_SEL  = 5;
    localparam int unsigned CB_EDGE_RISE = 6;
    localparam int unsigned CB_FILT_EN  = 7;
    // flags and interrupt enables
    localparam int unsigned FL_CAP      = 0;
    localparam int unsigned FL_CMP_A    = 1;

    localparam logic [3:0]  WGM_NORMAL  = 4'h0;
    localparam logic [3:0]  WGM_CTC_CMP = 4'h4;
    localparam logic [3:0]  WGM_PFC_CAP = 4'h8;
    localparam logic [3:0]  WGM_PFC_CMP = 4'h9;
    localparam logic [3:0]  WGM_CTC_CAP = 4'hc;
    localparam logic [3:0]  WGM_RSVD    = 4'hd;

    localparam logic [1:0]  COM_TOGGLE  = 2'h1;
    localparam logic [1:0]  COM_CLEAR   = 2'h2;
    localparam logic [1:0]  COM_SET     = 2'h3;

    localparam logic [15:0] CNT_MAX     = 16'hffff;
    localparam logic [15:0] CNT_BOTTOM  = 16'h0000;
    localparam logic [15:0] TOP_8       = 16'h00ff;
    localparam logic [15:0] TOP_9       = 16'h01ff;
    localparam logic [15:0] TOP_10      = 16'h03ff;

    typedef struct packed {
        logic [3:0]            wgm;
        logic [NCH-1:0][1:0]   com;
        logic                  filt_en;
        logic                  edge_rise;
        logic                  cmp_sel;
        logic [2:0]            flags;
        logic [2:0]            ien;
        logic [15:0]           cap;
        logic [NCH-1:0][15:0]  cmp;
        logic [NCH-1:0][15:0]  buff;
        logic [7:0]            temp;
        logic [FILT_LEN-2:0]   samp;
        logic                  filt_out;
        logic                  in_prev;
        logic [NCH-1:0]        match_q;
        logic                  block;
        logic                  top_skip;
        logic [NCH-1:0]        oc;
        logic [7:0]            rdata;
    } tcc_state_t;

    localparam tcc_state_t STATE_RESET = '0;
endpackage : tcc_pkg

// ==== src/tcc_capture_compare.sv ====
// input capture and dual output compare logic beside a 16-bit timer
`timescale 1ns/1ps
`default_nettype none

// Contract
// - trigger is the pin, or the comparator output when its select bit is set
// - a source switch may itself capture; software clears the flag afterwards
// - the noise filter adds four system clocks before the capture register updates
// - filter and edge detector work except in modes where capture sets top
// - a software-driven pin edge matching the edge setting captures
// - filter output changes only after four equal samples, then feeds edge detect
// - a dedicated bit in the second control register enables the filter
// - the filter samples every system clock, ignoring the prescaler
// - every capture overwrites the capture register, read or not
// - a set flag with enable requests interrupt; ack or write-one clears it
// - compare channel a can serve as counter top value
// - compare registers double buffered in pwm modes, updated at top or bottom
// - cpu writes go to the buffer when buffered, else to the compare register
// - compare reads return both bytes directly, not through the holding byte
// - high byte goes to holding register; low write loads all 16 bits at once
// - force strobe in non-pwm modes acts on output only, no flag, no counter
// - a counter write blocks all compare matches on the next timer tick
// - counter written equal to variable top in pwm modes skips that top until 0xffff
// - compare output state survives mode changes
// - output mode bits act at once, not buffered with the compare value
// - a capture copies the counter and sets the flag in the same clock
// - capture low read copies the high byte to the holding register
module tcc_capture_compare
    import tcc_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [7:0]        rdata_o,
    input  wire logic              capture_input_pin_i,
    input  wire logic              comparator_output_i,
    input  wire logic              timer_tick_i,
    input  wire logic [15:0]       counter_value_i,
    input  wire logic              counter_write_i,
    input  wire logic [15:0]       counter_wdata_i,
    input  wire logic              capture_ack_i,
    input  wire logic              compare_a_ack_i,
    input  wire logic              compare_b_ack_i,
    output logic                   capture_irq_o,
    output logic                   compare_a_irq_o,
    output logic                   compare_b_irq_o,
    output logic      [NCH-1:0]    compare_output_state_o,
    output logic      [15:0]       top_value_o,
    output logic                   top_match_o
);

    tcc_state_t       s_reg;
    tcc_state_t       s_next;
    logic             pwm;
    logic             cap_top;
    logic             var_top;
    logic [15:0]      top;
    logic             top_hit;
    logic             bot_hit;
    logic             upd;
    logic             src;
    logic             flt;
    logic             cap_evt;
    logic [NCH-1:0]   ev;
    logic [NCH-1:0]   frc;
    logic [2:0]       fset;
    logic [2:0]       fclr;
    logic [7:0]       rv;

    // output action of one channel on a match, a force or top
    function automatic logic wave(input logic oc, input logic [1:0] com, input logic pw,
                                  input logic hit, input logic at_top);
        logic r;
        r = oc;
        if (!pw)
        begin
            if (hit)
            begin
                case (com)
                    COM_TOGGLE: r = !oc;
                    COM_CLEAR:  r = 1'b0;
                    COM_SET:    r = 1'b1;
                    default:    r = oc;
                endcase
            end
        end
        else if (com[1])
        begin
            if (hit)
                r = !com[0];
            else if (at_top)
                r = com[0];
        end
        return r;
    endfunction : wave

    always_comb
    begin
        s_next  = s_reg;
        fset    = 3'h0;
        fclr    = 3'h0;
        rv      = 8'h00;
        ev      = '0;
        frc     = '0;
        pwm     = !(s_reg.wgm == WGM_NORMAL || s_reg.wgm == WGM_CTC_CMP
                    || s_reg.wgm == WGM_CTC_CAP);
        cap_top = s_reg.wgm[3] && !s_reg.wgm[0];
        var_top = s_reg.wgm[3] && pwm && s_reg.wgm != WGM_RSVD;
        case (s_reg.wgm)
            4'h1, 4'h5: top = TOP_8;
            4'h2, 4'h6: top = TOP_9;
            4'h3, 4'h7: top = TOP_10;
            4'h4, 4'h9, 4'hb, 4'hf: top = s_reg.cmp[0];
            4'h8, 4'ha, 4'hc, 4'he: top = s_reg.cap;
            default: top = CNT_MAX;
        endcase
        top_hit = timer_tick_i && counter_value_i == top && !s_reg.top_skip;
        bot_hit = timer_tick_i && counter_value_i == CNT_BOTTOM;
        // dual-slope modes take the new value at bottom, all others at top
        upd     = (s_reg.wgm == WGM_PFC_CAP || s_reg.wgm == WGM_PFC_CMP) ? bot_hit : top_hit;

        // capture path: source mux, filter, edge detector
        src = s_reg.cmp_sel ? comparator_output_i : capture_input_pin_i;
        flt = s_reg.filt_en ? s_reg.filt_out : src;
        cap_evt = 1'b0;
        if (!cap_top)
        begin
            // sampled every clock, the prescaler never gates it
            s_next.samp = {s_reg.samp[FILT_LEN-3:0], src};
            if (&{s_reg.samp, src})
                s_next.filt_out = 1'b1;
            else if (!(|{s_reg.samp, src}))
                s_next.filt_out = 1'b0;
            s_next.in_prev = flt;
            // a source or filter-enable switch can look like an edge here
            cap_evt = flt != s_reg.in_prev && flt == s_reg.edge_rise;
        end
        if (cap_evt)
        begin
            s_next.cap = counter_value_i;
            fset[FL_CAP] = 1'b1;
        end

        // counter written: block the next tick's matches, even if stopped
        if (counter_write_i)
            s_next.block = 1'b1;
        else if (timer_tick_i)
            s_next.block = 1'b0;
        if (counter_value_i == CNT_MAX)
            s_next.top_skip = 1'b0;
        if (counter_write_i && var_top && counter_wdata_i == top)
            s_next.top_skip = 1'b1;

        for (int i = 0; i < NCH; i++)
        begin
            if (timer_tick_i)
                s_next.match_q[i] = counter_value_i == s_reg.cmp[i] && !s_reg.block;
            ev[i] = timer_tick_i && s_reg.match_q[i];
            frc[i] = wr_i && addr_i == ADDR_CTRL_B && wdata_i[CB_FORCE_A+i] && !pwm;
            fset[FL_CMP_A+i] = ev[i];
            // mode bits read live each cycle; the output bit is never reset by a mode write
            s_next.oc[i] = wave(s_reg.oc[i], s_reg.com[i], pwm, ev[i] || frc[i], top_hit);
            if (pwm && upd)
                s_next.cmp[i] = s_reg.buff[i];
        end

        if (wr_i)
        begin
            unique case (addr_i)
                ADDR_CTRL_A:
                begin
                    s_next.wgm    = wdata_i[CA_WGM_LSB+:4];
                    s_next.com[1] = wdata_i[CA_COMB_LSB+:2];
                    s_next.com[0] = wdata_i[CA_COMA_LSB+:2];
                end
                ADDR_CTRL_B:
                begin
                    s_next.filt_en   = wdata_i[CB_FILT_EN];
                    s_next.edge_rise = wdata_i[CB_EDGE_RISE];
                    s_next.cmp_sel   = wdata_i[CB_CMP_SEL];
                end
                ADDR_FLAGS:  fclr = wdata_i[2:0];
                ADDR_IRQ_EN: s_next.ien = wdata_i[2:0];
                ADDR_CAP_HI, ADDR_CMPA_HI, ADDR_CMPB_HI:
                    s_next.temp = wdata_i;
                ADDR_CAP_LO:
                    if (cap_top)
                        s_next.cap = {s_reg.temp, wdata_i};
                ADDR_CMPA_LO, ADDR_CMPB_LO:
                begin
                    if (pwm)
                        s_next.buff[addr_i == ADDR_CMPB_LO] = {s_reg.temp, wdata_i};
                    else
                        s_next.cmp[addr_i == ADDR_CMPB_LO] = {s_reg.temp, wdata_i};
                end
                default: ;
            endcase
        end

        if (rd_i)
        begin
            unique case (addr_i)
                ADDR_CTRL_A: rv = {s_reg.com[0], s_reg.com[1], s_reg.wgm};
                ADDR_CTRL_B: rv = {s_reg.filt_en, s_reg.edge_rise, s_reg.cmp_sel, 5'h00};
                ADDR_FLAGS:  rv = {5'h00, s_reg.flags};
                ADDR_IRQ_EN: rv = {5'h00, s_reg.ien};
                ADDR_CAP_LO:
                begin
                    rv = s_reg.cap[7:0];
                    s_next.temp = s_reg.cap[15:8];
                end
                ADDR_CAP_HI: rv = s_reg.temp;
                ADDR_CMPA_LO: rv = pwm ? s_reg.buff[0][7:0] : s_reg.cmp[0][7:0];
                ADDR_CMPA_HI: rv = pwm ? s_reg.buff[0][15:8] : s_reg.cmp[0][15:8];
                ADDR_CMPB_LO: rv = pwm ? s_reg.buff[1][7:0] : s_reg.cmp[1][7:0];
                ADDR_CMPB_HI: rv = pwm ? s_reg.buff[1][15:8] : s_reg.cmp[1][15:8];
                default: rv = 8'h00;
            endcase
        end
        s_next.rdata = rv;

        // a new event wins over a clear in the same cycle
        s_next.flags = (s_reg.flags & ~fclr
                        & ~{compare_b_ack_i, compare_a_ack_i, capture_ack_i}) | fset;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            s_reg <= STATE_RESET;
        else
            s_reg <= s_next;
    end

    assign rdata_o                = s_reg.rdata;
    assign capture_irq_o          = s_reg.flags[0] && s_reg.ien[0];
    assign compare_a_irq_o        = s_reg.flags[1] && s_reg.ien[1];
    assign compare_b_irq_o        = s_reg.flags[2] && s_reg.ien[2];
    assign compare_output_state_o = s_reg.oc;
    assign top_value_o            = top;
    assign top_match_o            = top_hit;

    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    src_sel_a: assert property (!cap_top && !s_reg.filt_en && s_reg.cmp_sel && s_reg.edge_rise
        && comparator_output_i && !s_reg.in_prev |-> cap_evt)
        else $error("comparator edge did not capture");

    cap_copy_a: assert property (cap_evt |=> s_reg.cap == $past(counter_value_i)
        && s_reg.flags[FL_CAP])
        else $error("capture value or flag wrong");

    cap_off_a: assert property (cap_top |-> !cap_evt ##1 ($stable(s_reg.samp)
        && $stable(s_reg.in_prev)))
        else $error("capture in capture-top mode");

    filt_hold_a: assert property (s_reg.filt_en && !cap_top && !(&{s_reg.samp, src})
        && (|{s_reg.samp, src}) |=> $stable(s_reg.filt_out))
        else $error("filter moved on mixed samples");

    blk_match_a: assert property (timer_tick_i && s_reg.block |=> s_reg.match_q == '0)
        else $error("match after counter write");

    flag_next_a: assert property (timer_tick_i && s_reg.match_q[0] |=> s_reg.flags[FL_CMP_A])
        else $error("compare flag not set");

    flag_clr_a: assert property (wr_i && addr_i == ADDR_FLAGS && wdata_i[FL_CMP_A]
        && !ev[0] |=> !s_reg.flags[FL_CMP_A] && !compare_a_irq_o)
        else $error("compare flag not cleared");

    direct_wr_a: assert property (wr_i && addr_i == ADDR_CMPA_LO && !pwm
        |=> s_reg.cmp[0] == {$past(s_reg.temp), $past(wdata_i)})
        else $error("direct compare write wrong");

    buf_hold_a: assert property (wr_i && addr_i == ADDR_CMPA_LO && pwm && !upd
        |=> $stable(s_reg.cmp[0]) ##0 s_reg.buff[0][7:0] == $past(wdata_i))
        else $error("buffered write leaked");

    force_tog_a: assert property (frc[0] && s_reg.com[0] == COM_TOGGLE && !ev[0]
        && !s_reg.flags[FL_CMP_A] |=> s_reg.oc[0] != $past(s_reg.oc[0]) && !s_reg.flags[FL_CMP_A])
        else $error("force did not toggle");

    top_skip_a: assert property (counter_write_i && var_top && counter_wdata_i == top
        |=> s_reg.top_skip ##0 !top_match_o)
        else $error("top not skipped");

    filt_rise_a: assert property (!cap_top && (&{s_reg.samp, src})
        |=> s_reg.filt_out)
        else $error("filter missed four high samples");

    filt_fall_a: assert property (!cap_top && !(|{s_reg.samp, src})
        |=> !s_reg.filt_out)
        else $error("filter missed four low samples");

    flag_b_a: assert property (ev[1] |=> s_reg.flags[FL_CMP_A+1])
        else $error("compare b flag not set");

    cap_ack_a: assert property (capture_ack_i && !cap_evt |=> !s_reg.flags[FL_CAP])
        else $error("capture flag survived ack");

    rd_direct_a: assert property (rd_i && addr_i == ADDR_CMPA_HI && !pwm
        |=> rdata_o == $past(s_reg.cmp[0][15:8]))
        else $error("compare high byte read wrong");

    cap_hold_a: assert property (rd_i && addr_i == ADDR_CAP_LO
        |=> s_reg.temp == $past(s_reg.cap[15:8]))
        else $error("capture high byte not held");

    hold_wr_a: assert property (wr_i && addr_i == ADDR_CMPB_HI
        |=> s_reg.temp == $past(wdata_i))
        else $error("holding byte not written");

    buf_load_a: assert property (pwm && upd |=> s_reg.cmp[1] == $past(s_reg.buff[1]))
        else $error("buffer not loaded");

    oc_keep_a: assert property (wr_i && addr_i == ADDR_CTRL_A && !ev[0] && !top_hit
        |=> $stable(s_reg.oc[0]))
        else $error("output state lost on mode write");

    force_pwm_a: assert property (wr_i && addr_i == ADDR_CTRL_B && pwm
        && !ev[0] && !top_hit |=> $stable(s_reg.oc[0]))
        else $error("force acted in pwm mode");

    skip_clr_a: assert property (s_reg.top_skip && counter_value_i == CNT_MAX
        && !counter_write_i |=> !s_reg.top_skip)
        else $error("top skip not released");

    block_clr_a: assert property (timer_tick_i && !counter_write_i |=> !s_reg.block)
        else $error("match block outlived its tick");

    cap_filt_c: cover property (cap_evt && s_reg.filt_en);
    force_c:    cover property (frc[0] ##1 frc[1]);
    skip_c:     cover property (s_reg.top_skip && counter_value_i == CNT_MAX);
    buf_upd_c:  cover property (pwm && upd && s_reg.cmp[0] != s_reg.buff[0]);
    cap_ack_c:  cover property (capture_ack_i && s_reg.flags[FL_CAP]);

endmodule : tcc_capture_compare

`default_nettype wire

// ==== sim/tcc_cpu_model.sv ====
// cpu model driving the register port of the capture/compare block
`timescale 1ns/1ps
`default_nettype none
module tcc_cpu_model
    import tcc_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic [7:0]        rdata_i,
    output logic      [ADDR_W-1:0] addr_o,
    output logic      [7:0]        wdata_o,
    output logic                   wr_o,
    output logic                   rd_o,
    output logic      [2:0]        ack_o
);
    initial
    begin
        addr_o  = '0;
        wdata_o = '0;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        ack_o   = 3'h0;
    end

    // idle bus shows inverted leftovers, never the last value
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        @(posedge clk_i);
        d = rdata_i;
    endtask : rd

    // high byte first into the holding byte, low byte commits
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        wr(a + 4'h1, v[15:8]);
        wr(a, v[7:0]);
    endtask : wr16

    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a + 4'h1, v[15:8]);
    endtask : rd16

    // needed after any source or filter-enable change
    task automatic clr_flags();
        wr(ADDR_FLAGS, 8'h07);
    endtask : clr_flags

    task automatic ack(input int unsigned ch);
        @(posedge clk_i);
        ack_o[ch] <= 1'b1;
        @(posedge clk_i);
        ack_o <= 3'h0;
    endtask : ack
endmodule : tcc_cpu_model
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench of the capture/compare block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import tcc_pkg::*;
;
    localparam logic [1:0] COMS [4] = '{COM_TOGGLE, COM_SET, COM_CLEAR, COM_TOGGLE};
    logic              clk_i;
    logic              rst_b_i;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic [7:0]        rdata;
    logic              wr;
    logic              rd;
    logic [2:0]        ack;
    logic              pin;
    logic              cmpo;
    logic              tick;
    logic              cwr;
    logic [15:0]       cnt;
    logic [15:0]       cwd;
    logic              cap_irq;
    logic [1:0]        cirq;
    logic [NCH-1:0]    oc;
    logic [NCH-1:0]    exp_oc;
    logic [15:0]       top;
    logic              top_m;
    logic [31:0]       seed;
    logic [15:0]       v1;
    logic [15:0]       v2;
    logic [15:0]       got;
    logic [7:0]        rd8;
    int                n_fail;
    int                total_checks;

    initial clk_i = 1'b0;
    always #2 clk_i = ~clk_i;

    tcc_capture_compare uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .capture_input_pin_i(pin), .comparator_output_i(cmpo), .timer_tick_i(tick),
        .counter_value_i(cnt), .counter_write_i(cwr), .counter_wdata_i(cwd),
        .capture_ack_i(ack[0]), .compare_a_ack_i(ack[1]), .compare_b_ack_i(ack[2]),
        .capture_irq_o(cap_irq), .compare_a_irq_o(cirq[0]), .compare_b_irq_o(cirq[1]),
        .compare_output_state_o(oc), .top_value_o(top), .top_match_o(top_m));
    tcc_cpu_model cpu (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd), .ack_o(ack));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lfsr

    function automatic logic oc_next(input logic [1:0] com, input logic o);
        return (com == COM_TOGGLE) ? ~o : (com == COM_SET) ? 1'b1 :
               (com == COM_CLEAR) ? 1'b0 : o;
    endfunction : oc_next

    task automatic rnd16(output logic [15:0] v);
        seed = lfsr(seed);
        v = seed[15:0];
    endtask : rnd16

    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %0t %s got %h want %h", $time, m, g, e);
        end
    endtask : chk

    task automatic tick_at(input logic [15:0] v);
        @(posedge clk_i);
        cnt  <= v;
        tick <= 1'b1;
        @(posedge clk_i);
        tick <= 1'b0;
    endtask : tick_at

    // counter write pulse; blocks the next tick's matches
    task automatic cnt_write(input logic [15:0] v);
        @(posedge clk_i);
        cwr <= 1'b1;
        cwd <= v;
        @(posedge clk_i);
        cwr <= 1'b0;
    endtask : cnt_write

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    initial
    begin
        #80000;
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        end_of_test();
    end

    initial
    begin
        seed = 32'h47ff4adf;
        {pin, cmpo, tick, cwr, cnt, cwd, n_fail, total_checks} = '0;
        exp_oc = 2'b00;
        rst_b_i = 1'b0;
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        cpu.rd(ADDR_FLAGS, rd8);
        chk(16'(rd8), 16'h0, "flags after reset");
        cpu.rd(4'ha, rd8);
        chk(16'(rd8), 16'h0, "unmapped read");
        chk(top, CNT_MAX, "top after reset");
        $display("test reset done");
        cpu.wr(ADDR_IRQ_EN, 8'h07);
        for (int ch = 0; ch < 2; ch++)
        begin
            rnd16(v1);
            if (ch == 1)
                v1 = CNT_MAX;
            cpu.wr16(ADDR_CMPA_LO + 4'(2 * ch), v1);
            cpu.rd16(ADDR_CMPA_LO + 4'(2 * ch), got);
            chk(got, v1, "compare readback");
            cnt_write(v1);
            tick_at(v1);
            tick_at(~v1);
            @(negedge clk_i);
            chk(16'(cirq[ch]), 16'h0, "blocked match flagged");
            tick_at(v1);
            @(negedge clk_i);
            chk(16'(cirq[ch]), 16'h0, "flag before next tick");
            tick_at(~v1);
            @(negedge clk_i);
            chk(16'(cirq[ch]), 16'h1, "match flag");
            cpu.ack(ch + 1);
            @(negedge clk_i);
            chk(16'(cirq[ch]), 16'h0, "ack clear");
            tick_at(v1);
            tick_at(~v1);
            cpu.wr(ADDR_FLAGS, 8'(2 << ch));
            @(negedge clk_i);
            chk(16'(cirq[ch]), 16'h0, "write one clear");
        end
        $display("test compare done");
        for (int ch = 0; ch < 2; ch++)
            for (int i = 0; i < 4; i++)
            begin
                cpu.wr(ADDR_CTRL_A, 8'(COMS[i]) << (ch ? CA_COMB_LSB : CA_COMA_LSB));
                cpu.wr(ADDR_CTRL_B, 8'(1) << (CB_FORCE_A + ch));
                @(negedge clk_i);
                exp_oc[ch] = oc_next(COMS[i], exp_oc[ch]);
                chk(16'(oc), 16'(exp_oc), "forced output");
                chk(16'(cirq), 16'h0, "force set a flag");
            end
        cpu.wr(ADDR_CTRL_A, 8'h05);
        cpu.wr(ADDR_CTRL_B, 8'h03);
        @(negedge clk_i);
        chk(16'(oc), 16'(exp_oc), "output after mode change");
        $display("test force done");
        rnd16(v1);
        v1[15] = 1'b0;
        v2 = v1 + 16'h0101;
        cpu.wr(ADDR_CTRL_A, {4'h0, WGM_CTC_CMP});
        cpu.wr16(ADDR_CMPA_LO, v1);
        @(negedge clk_i);
        chk(top, v1, "unbuffered top");
        cpu.wr(ADDR_CTRL_A, 8'h0f);
        cpu.wr16(ADDR_CMPA_LO, v2);
        @(negedge clk_i);
        chk(top, v1, "buffered top early");
        cpu.rd16(ADDR_CMPA_LO, got);
        chk(got, v2, "buffer readback");
        tick_at(v1);
        @(negedge clk_i);
        chk(top, v2, "buffer loaded at top");
        cnt_write(v2);
        cnt  <= v2;
        tick <= 1'b1;
        @(negedge clk_i);
        chk(16'(top_m), 16'h0, "top after counter write");
        @(posedge clk_i);
        tick <= 1'b0;
        cnt  <= CNT_MAX;
        @(posedge clk_i);
        cnt  <= v2;
        tick <= 1'b1;
        @(negedge clk_i);
        chk(16'(top_m), 16'h1, "top match after wrap");
        @(posedge clk_i);
        tick <= 1'b0;
        $display("test top done");
        cpu.wr(ADDR_CTRL_A, 8'h00);
        cpu.wr(ADDR_CTRL_B, 8'h40);
        cpu.clr_flags();
        for (int i = 0; i < 3; i++)
        begin
            rnd16(v1);
            cpu.clr_flags();
            @(posedge clk_i);
            cnt <= v1;
            pin <= 1'b1;
            @(posedge clk_i);
            pin <= 1'b0;
            @(negedge clk_i);
            chk(16'(cap_irq), 16'h1, "pin capture");
        end
        cpu.rd16(ADDR_CAP_LO, got);
        chk(got, v1, "capture overwrite");
        cpu.wr(ADDR_CTRL_B, 8'h60);
        cpu.clr_flags();
        @(posedge clk_i);
        pin <= 1'b1;
        repeat (3) @(posedge clk_i);
        cmpo <= 1'b1;
        cnt  <= v2;
        @(negedge clk_i);
        chk(16'(cap_irq), 16'h0, "pin ignored");
        @(negedge clk_i);
        chk(16'(cap_irq), 16'h1, "comparator capture");
        cpu.rd16(ADDR_CAP_LO, got);
        chk(got, v2, "comparator value");
        @(posedge clk_i);
        {pin, cmpo} <= 2'b00;
        cpu.wr(ADDR_CTRL_B, 8'hc0);
        repeat (8) @(posedge clk_i);
        cpu.clr_flags();
        // three high samples: too short to pass
        pin <= 1'b1;
        repeat (3) @(posedge clk_i);
        pin <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk(16'(cap_irq), 16'h0, "glitch captured");
        pin <= 1'b1;
        cnt <= v1;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        chk(16'(cap_irq), 16'h0, "filter too fast");
        @(negedge clk_i);
        chk(16'(cap_irq), 16'h1, "filtered capture");
        cpu.rd16(ADDR_CAP_LO, got);
        chk(got, v1, "filtered value");
        cpu.wr(ADDR_CTRL_A, {4'h0, WGM_CTC_CAP});
        cpu.wr(ADDR_CTRL_B, 8'h00);
        cpu.clr_flags();
        pin <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk(16'(cap_irq), 16'h0, "capture in capture-top mode");
        cpu.wr16(ADDR_CAP_LO, v2);
        cpu.rd16(ADDR_CAP_LO, got);
        chk(got, v2, "capture register write");
        chk(top, v2, "capture as top");
        cpu.wr(ADDR_CTRL_A, 8'h00);
        cpu.clr_flags();
        @(posedge clk_i);
        pin <= 1'b1;
        @(posedge clk_i);
        pin <= 1'b0;
        cnt <= v2 ^ 16'h00ff;
        @(negedge clk_i);
        chk(16'(cap_irq), 16'h0, "rising edge captured");
        @(negedge clk_i);
        chk(16'(cap_irq), 16'h1, "falling capture");
        cpu.ack(0);
        @(negedge clk_i);
        chk(16'(cap_irq), 16'h0, "capture ack clear");
        cpu.rd16(ADDR_CAP_LO, got);
        chk(got, v2 ^ 16'h00ff, "falling value");
        $display("test capture done");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
